// >>> hw/pdc_top.v
// loop-2 divider configuration bank with axi4-lite slave and divider datapath
// assumes reference and vco event pins are asynchronous slow edges (< sys clk / 4)
// Summary of operation
// (R01) 12-bit reference divider: high nibble plus low byte; zero is invalid, no output.
// (R02) prescaler field 7:5: code 0 divides by 8, 1-2 by 2, else by code.
// (R03) prescaler input comes from the vco output picked by the mode selector.
// (R04) software must set the reference range code; codes 3,5,6,7 reserved.
// (R05) bit 0 enables the reference doubler, doubling comparison rate.
// (R06) reserved bits read zero; writes to them change nothing.
`include "pdc_regs.vh"
`default_nettype none
module pdc_top #(
  parameter DIV_W = 12
) (
  // clock and reset
  input wire I_CLK_SYS,
  input wire I_ARST_N,
  // axi4-lite write address and data
  input wire I_AWVALID,
  output wire O_AWREADY,
  input wire [13:0] I_AWADDR,
  input wire I_WVALID,
  output wire O_WREADY,
  input wire [31:0] I_WDATA,
  input wire [3:0] I_WSTRB,
  // axi4-lite write response
  output reg O_BVALID,
  input wire I_BREADY,
  output reg [1:0] O_BRESP,
  // axi4-lite read
  input wire I_ARVALID,
  output wire O_ARREADY,
  input wire [13:0] I_ARADDR,
  output reg O_RVALID,
  input wire I_RREADY,
  output reg [31:0] O_RDATA,
  output reg [1:0] O_RRESP,
  // loop inputs: reference, the two vco outputs and the mode selector, asynchronous
  input wire I_REF_CLK,
  input wire I_VCO_A,
  input wire I_VCO_B,
  input wire I_FIRST_MODE_SELECTOR,
  // loop outputs
  output reg O_REF_CMP_PULSE,
  output wire O_FB_PRESC_PULSE,
  output reg [2:0] O_REF_INPUT_RANGE_CODE,
  output reg O_RANGE_CODE_RESERVED
);
  reg [1:0] rst_sync_q;
  wire rst_n;
  reg [7:0] div_high_q;
  reg [7:0] div_low_q;
  reg [7:0] presc_q;
  reg [13:0] awaddr_q;
  reg aw_have_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg w_have_q;
  reg [2:0] ref_s_q;
  reg [2:0] vco_a_s_q;
  reg [2:0] vco_b_s_q;
  reg [1:0] sel_s_q;
  reg [2:0] presc_ratio;
  wire [DIV_W-1:0] loop2_ref_divider;
  wire [2:0] loop2_vco_prescaler;
  wire ref_doubler_enable;
  wire ref_event;
  wire vco_event;
  wire ref_div_pulse;
  wire do_write;

  // release reset through two flops so every flop leaves reset together
  always @(posedge I_CLK_SYS or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // register index from a byte address; low two bits ignored
  function [11:0] reg_index;
    input [13:0] addr;
    begin
      reg_index = addr[13:2];
    end
  endfunction

  // field views of the stored registers
  assign loop2_ref_divider = {div_high_q[`PDC_REF_DIV_HIGH_MSB:0], div_low_q}; // R01
  assign loop2_vco_prescaler = presc_q[`PDC_PRESC_MSB:`PDC_PRESC_LSB];
  assign ref_doubler_enable = presc_q[`PDC_DBL_BIT];

  // write channel: address and data taken in either order, one at a time
  assign O_AWREADY = !aw_have_q && !O_BVALID;
  assign O_WREADY = !w_have_q && !O_BVALID;
  assign do_write = aw_have_q && w_have_q && !O_BVALID;

  always @(posedge I_CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 14'h0000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      O_BVALID <= 1'b0;
      O_BRESP <= 2'b00;
      div_high_q <= `PDC_RST_REF_DIV_HIGH;
      div_low_q <= `PDC_RST_REF_DIV_LOW;
      presc_q <= `PDC_RST_PRESC_RANGE_DBL;
    end
    else
    begin
      if (I_AWVALID && O_AWREADY)
      begin
        aw_have_q <= 1'b1;
        awaddr_q <= I_AWADDR;
      end
      if (I_WVALID && O_WREADY)
      begin
        w_have_q <= 1'b1;
        wdata_q <= I_WDATA;
        wstrb_q <= I_WSTRB;
      end
      if (O_BVALID && I_BREADY)
        O_BVALID <= 1'b0;
      if (do_write)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        O_BVALID <= 1'b1;
        O_BRESP <= 2'b00;
        // masks keep reserved bits at zero
        if (reg_index(awaddr_q) == `PDC_IDX_REF_DIV_HIGH)
        begin
          if (wstrb_q[0])
            div_high_q <= wdata_q[7:0] & `PDC_MASK_REF_DIV_HIGH; // R06
        end
        else if (reg_index(awaddr_q) == `PDC_IDX_REF_DIV_LOW)
        begin
          if (wstrb_q[0])
            div_low_q <= wdata_q[7:0] & `PDC_MASK_REF_DIV_LOW;
        end
        else if (reg_index(awaddr_q) == `PDC_IDX_PRESC_RANGE_DBL)
        begin
          if (wstrb_q[0])
            presc_q <= wdata_q[7:0] & `PDC_MASK_PRESC_RANGE_DBL; // R06
        end
        else if (reg_index(awaddr_q) != `PDC_IDX_STATUS)
          O_BRESP <= 2'b10; // slverr for unmapped address
      end
    end
  end

  // read channel: one outstanding read, answer the cycle after arvalid
  assign O_ARREADY = !O_RVALID;

  always @(posedge I_CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      O_RVALID <= 1'b0;
      O_RDATA <= 32'h00000000;
      O_RRESP <= 2'b00;
    end
    else if (O_RVALID)
    begin
      if (I_RREADY)
        O_RVALID <= 1'b0;
    end
    else if (I_ARVALID)
    begin
      O_RVALID <= 1'b1;
      O_RRESP <= 2'b00;
      // upper bits and reserved bits read as zero
      if (reg_index(I_ARADDR) == `PDC_IDX_REF_DIV_HIGH)
        O_RDATA <= {24'h000000, div_high_q}; // R06
      else if (reg_index(I_ARADDR) == `PDC_IDX_REF_DIV_LOW)
        O_RDATA <= {24'h000000, div_low_q};
      else if (reg_index(I_ARADDR) == `PDC_IDX_PRESC_RANGE_DBL)
        O_RDATA <= {24'h000000, presc_q};
      else if (reg_index(I_ARADDR) == `PDC_IDX_STATUS)
        O_RDATA <= {30'h00000000, O_RANGE_CODE_RESERVED, loop2_ref_divider == {DIV_W{1'b0}}};
      else
      begin
        O_RDATA <= 32'h00000000;
        O_RRESP <= 2'b10;
      end
    end
  end

  // pin synchronisers; edge logic reads only stage two and later
  always @(posedge I_CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_s_q <= 3'b000;
      vco_a_s_q <= 3'b000;
      vco_b_s_q <= 3'b000;
      sel_s_q <= 2'b00;
    end
    else
    begin
      ref_s_q <= {ref_s_q[1:0], I_REF_CLK};
      vco_a_s_q <= {vco_a_s_q[1:0], I_VCO_A};
      vco_b_s_q <= {vco_b_s_q[1:0], I_VCO_B};
      sel_s_q <= {sel_s_q[0], I_FIRST_MODE_SELECTOR};
    end
  end

  // doubler counts both reference edges, otherwise rising only
  assign ref_event = ref_doubler_enable ? (ref_s_q[2] ^ ref_s_q[1]) // R05
                                        : (ref_s_q[1] & ~ref_s_q[2]);
  // prescaler input taken from the selected vco output
  assign vco_event = sel_s_q[1] ? (vco_b_s_q[1] & ~vco_b_s_q[2]) // R03
                                : (vco_a_s_q[1] & ~vco_a_s_q[2]);

  // prescaler code to ratio
  always @*
  begin
    if (loop2_vco_prescaler == 3'h0)
      presc_ratio = 3'h0; // R02: divide by 8; ratio 0 is mapped to 4'h8 at the prescaler
    else if (loop2_vco_prescaler == 3'h1)
      presc_ratio = 3'h2; // R02
    else
      presc_ratio = loop2_vco_prescaler; // R02
  end

  // reference divider; zero ratio makes no pulses
  pdc_clk_div #(
    .WIDTH(DIV_W)
  ) u_ref_div (
    .i_clk(I_CLK_SYS),
    .i_rst_n(rst_n),
    .i_in_en(ref_event),
    .i_ratio(loop2_ref_divider), // R01
    .o_pulse(ref_div_pulse)
  );

  // prescaler; a four-bit ratio gives eight for code zero
  pdc_clk_div #(
    .WIDTH(4)
  ) u_presc (
    .i_clk(I_CLK_SYS),
    .i_rst_n(rst_n),
    .i_in_en(vco_event),
    .i_ratio((presc_ratio == 3'h0) ? 4'h8 : {1'b0, presc_ratio}), // R02
    .o_pulse(O_FB_PRESC_PULSE)
  );

  // registered outputs toward the calibration logic
  always @(posedge I_CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      O_REF_CMP_PULSE <= 1'b0;
      O_REF_INPUT_RANGE_CODE <= 3'h3;
      O_RANGE_CODE_RESERVED <= 1'b1;
    end
    else
    begin
      O_REF_CMP_PULSE <= ref_div_pulse;
      O_REF_INPUT_RANGE_CODE <= presc_q[`PDC_RANGE_MSB:`PDC_RANGE_LSB];
      // flag reserved codes; software owns picking a valid one
      O_RANGE_CODE_RESERVED <= (presc_q[4:2] == 3'h3) || (presc_q[4:2] > 3'h4); // R04
    end
  end
endmodule // pdc_top
`default_nettype wire

// >>> hw/pdc_regs.vh
// register offsets, field positions, reset values for the loop-2 divider config bank
// assumes byte addresses on a 32-bit axi4-lite bus, one register per aligned word
`ifndef PDC_REGS_VH
`define PDC_REGS_VH
// printed offsets are register indices; byte address is four times the index
`define PDC_IDX_REF_DIV_HIGH 12'h160
`define PDC_IDX_REF_DIV_LOW 12'h161
`define PDC_IDX_PRESC_RANGE_DBL 12'h162
`define PDC_IDX_STATUS 12'h170
// field positions
`define PDC_REF_DIV_HIGH_MSB 3
`define PDC_PRESC_MSB 7
`define PDC_PRESC_LSB 5
`define PDC_RANGE_MSB 4
`define PDC_RANGE_LSB 2
`define PDC_DBL_BIT 0
// reset values
`define PDC_RST_REF_DIV_HIGH 8'h00
`define PDC_RST_REF_DIV_LOW 8'h02
`define PDC_RST_PRESC_RANGE_DBL 8'h4d
// writable bit masks: reserved bits stay zero
`define PDC_MASK_REF_DIV_HIGH 8'h0f
`define PDC_MASK_REF_DIV_LOW 8'hff
`define PDC_MASK_PRESC_RANGE_DBL 8'hfd
`endif

// >>> hw/pdc_clk_div.v
// programmable divider: one-cycle enable pulse every ratio input edges
// assumes i_in_en marks input events in the system clock domain
`default_nettype none
module pdc_clk_div #(
  parameter WIDTH = 12
) (
  // clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // control
  input wire i_in_en,
  input wire [WIDTH-1:0] i_ratio,
  // output
  output reg o_pulse
);
  reg [WIDTH-1:0] cnt_q;

  // count input events; ratio zero clears the count and stops the divider
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_q <= {WIDTH{1'b0}};
      o_pulse <= 1'b0;
    end
    else
    begin
      o_pulse <= 1'b0;
      if (i_ratio == {WIDTH{1'b0}})
        cnt_q <= {WIDTH{1'b0}};
      else if (i_in_en)
      begin
        if (cnt_q >= i_ratio - {{(WIDTH-1){1'b0}}, 1'b1})
        begin
          cnt_q <= {WIDTH{1'b0}};
          o_pulse <= 1'b1;
        end
        else
          cnt_q <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // pdc_clk_div
`default_nettype wire

// >>> dv/pdc_top_monitor.sv
// assertion checker for the loop-2 divider config bank
// assumes a bind onto pdc_top, one system clock domain
`default_nettype none
module pdc_top_monitor (
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_ARST_N,
  // bus side
  input wire logic I_ARVALID,
  input wire logic O_ARREADY,
  input wire logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [1:0] O_BRESP,
  input wire logic O_AWREADY,
  input wire logic O_WREADY,
  // loop side
  input wire logic O_REF_CMP_PULSE,
  input wire logic [2:0] O_REF_INPUT_RANGE_CODE,
  input wire logic O_RANGE_CODE_RESERVED
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_ARST_N);
  // read and write steps as sequences
  sequence rd_req;
    I_ARVALID && O_ARREADY;
  endsequence
  sequence wr_done;
    O_BVALID && I_BREADY;
  endsequence
  read_answer_a: assert property (rd_req |=> O_RVALID) else $error("read not answered");
  read_hold_a: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
    else $error("read data dropped");
  write_hold_a: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
    else $error("write response dropped");
  write_refuse_a: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
    else $error("write taken during response");
  write_reopen_a: assert property (wr_done |=> O_AWREADY && O_WREADY)
    else $error("write path stays closed");
  read_refuse_a: assert property (O_RVALID |-> !O_ARREADY) else $error("read taken early");
  upper_zero_a: assert property (O_RVALID |-> O_RDATA[31:8] == 24'h0)
    else $error("upper read bits set");
  range_flag_a: assert property (O_RANGE_CODE_RESERVED ==
    (O_REF_INPUT_RANGE_CODE inside {3'h3, 3'h5, 3'h6, 3'h7})) else $error("range flag wrong");
  ref_single_a: assert property (O_REF_CMP_PULSE |=> !O_REF_CMP_PULSE)
    else $error("reference pulse too long");
endmodule // pdc_top_monitor
bind pdc_top pdc_top_monitor mon_u (.I_CLK_SYS(I_CLK_SYS), .I_ARST_N(I_ARST_N),
  .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY),
  .O_RDATA(O_RDATA), .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .O_BRESP(O_BRESP),
  .O_AWREADY(O_AWREADY), .O_WREADY(O_WREADY), .O_REF_CMP_PULSE(O_REF_CMP_PULSE),
  .O_REF_INPUT_RANGE_CODE(O_REF_INPUT_RANGE_CODE),
  .O_RANGE_CODE_RESERVED(O_RANGE_CODE_RESERVED));
`default_nettype wire

// >>> dv/pdc_top_tb_top.sv
// self-checking bench for the loop-2 divider config bank
// assumes pdc_top with its bound checker; bench acts as axi4-lite master
`default_nettype none
module pdc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, awv, wv, bready, arv, rready, sel, awr, wrd, bv, arr, rv, rp, fp, rsv;
  logic [13:0] aa, ra;
  logic [31:0] wd, rd;
  logic [2:0] ev, rc_o;
  logic [1:0] br, rr;
  logic [3:0] ws;
  int num_errors = 0, compares = 0, pc = 0, fc = 0, s;
  pdc_top dut_u (.I_CLK_SYS(clk), .I_ARST_N(rst_n), .I_AWVALID(awv), .O_AWREADY(awr),
    .I_AWADDR(aa), .I_WVALID(wv), .O_WREADY(wrd), .I_WDATA(wd), .I_WSTRB(ws),
    .O_BVALID(bv), .I_BREADY(bready), .O_BRESP(br), .I_ARVALID(arv), .O_ARREADY(arr),
    .I_ARADDR(ra), .O_RVALID(rv), .I_RREADY(rready), .O_RDATA(rd), .O_RRESP(rr),
    .I_REF_CLK(ev[0]), .I_VCO_A(ev[1]), .I_VCO_B(ev[2]), .I_FIRST_MODE_SELECTOR(sel),
    .O_REF_CMP_PULSE(rp), .O_FB_PRESC_PULSE(fp), .O_REF_INPUT_RANGE_CODE(rc_o),
    .O_RANGE_CODE_RESERVED(rsv));
  // 200 MHz system clock
  initial
  begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  // divider output pulse counters
  always @(posedge clk)
  begin
    if (rp === 1'b1) pc++;
    if (fp === 1'b1) fc++;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // write: address and data offered together, each released when taken
  task wr(input logic [13:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ad, dd;
    ad = 0;
    dd = 0;
    aa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    while (!(ad && dd))
    begin
      @(posedge clk);
      if (!ad && awr)
      begin
        ad = 1;
        awv <= 0;
      end
      if (!dd && wrd)
      begin
        dd = 1;
        wv <= 0;
      end
    end
    bready <= 1;
    do @(posedge clk); while (!bv);
    bready <= 0;
    chk(br, er);
  endtask
  task rdc(input logic [13:0] a, input logic [31:0] e, input logic [1:0] er);
    ra <= a;
    arv <= 1;
    do @(posedge clk); while (!arr);
    arv <= 0;
    rready <= 1;
    do @(posedge clk); while (!rv);
    rready <= 0;
    chk(rd, e);
    chk(rr, er);
  endtask
  // slow edges on an event pin: 4 cycles high, 4 low, well under the sync limit
  task edg(input int k, input int n);
    repeat (n)
    begin
      ev[k] <= 1;
      repeat (4) @(posedge clk);
      ev[k] <= 0;
      repeat (4) @(posedge clk);
    end
    repeat (10) @(posedge clk);
  endtask
  task results;
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // watchdog well beyond the expected few thousand cycles
  initial
  begin
    #200000;
    num_errors++;
    results();
  end
  initial
  begin
    {rst_n, awv, wv, bready, arv, rready, sel} = 0;
    {aa, ra, wd, ev} = 0;
    ws = 4'hf;
    repeat (5) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    rdc(14'h580, 32'h00, 2'b00);
    rdc(14'h584, 32'h02, 2'b00);
    rdc(14'h588, 32'h4d, 2'b00);
    rdc(14'h600, 32'h00, 2'b10);
    wr(14'h600, 32'hff, 2'b10);
    wr(14'h580, 32'hf0, 2'b00);
    rdc(14'h580, 32'h00, 2'b00);
    // every prescaler and range code, selected vco alternating
    for (int c = 0; c < 8; c++)
    begin
      sel <= c[0];
      wr(14'h588, {24'h0, c[2:0], c[2:0], 2'b11}, 2'b00);
      rdc(14'h588, {24'h0, c[2:0], c[2:0], 2'b01}, 2'b00);
      chk(rc_o, c);
      chk(rsv, c == 3 || c > 4);
      rdc(14'h5c0, {30'h0, c == 3 || c > 4, 1'b0}, 2'b00);
      edg(1 + c[0], 8);
      s = fc;
      edg(1 + c[0], 3 * (c == 0 ? 8 : c < 3 ? 2 : c));
      chk(fc - s, 3);
    end
    s = fc;
    edg(1, 16);
    chk(fc - s, 0);
    wr(14'h584, 32'h03, 2'b00);
    for (int d = 0; d < 2; d++)
    begin
      wr(14'h588, d, 2'b00);
      edg(0, 6);
      s = pc;
      edg(0, 6);
      chk(pc - s, d ? 4 : 2);
    end
    // lane 0 strobe low: the write is answered but nothing changes
    ws <= 4'he;
    wr(14'h584, 32'h00, 2'b00);
    ws <= 4'hf;
    rdc(14'h584, 32'h03, 2'b00);
    wr(14'h584, 32'h00, 2'b00);
    s = pc;
    edg(0, 6);
    chk(pc - s, 0);
    // status word flags the zero divider; writes to it are ignored
    wr(14'h5c0, 32'hff, 2'b00);
    rdc(14'h5c0, 32'h01, 2'b00);
    // second reset in mid-run brings back every default
    rst_n <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    chk(rc_o, 3);
    chk(rsv, 1);
    rdc(14'h584, 32'h02, 2'b00);
    rdc(14'h588, 32'h4d, 2'b00);
    results();
  end
endmodule // pdc_top_tb_top
`default_nettype wire
